//--- logic/ucm_byte_reg.sv
// Byte-wide register with write enable and constant reset value.
`timescale 1ns/100ps
`default_nettype none
`include "ucm_defs.svh"

module ucm_byte_reg
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // Stored value
   output logic      [7:0] value
);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         value <= `UCM_SETUP_RESET;
      else if (wr_en)
         value <= wr_data;
   end

endmodule

`default_nettype wire

//--- logic/ucm_defs.svh
// Constants for the channel mode and loopback block.
`ifndef UCM_DEFS_SVH
`define UCM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addressing
// ----------------------------------------------------------------------------
`define UCM_ADDR_W        8
`define UCM_IDX_POINTER   6'h00
`define UCM_IDX_SETUP     6'h22
`define UCM_IDX_STATUS    6'h24
`define UCM_IDX_LSB       2

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define UCM_MODE_MSB      7
`define UCM_MODE_LSB      6
`define UCM_SETUP_RESET   8'h00
`define UCM_BYTE_ZERO     8'h00
`define UCM_WORD_ZERO     32'h0000_0000
`define UCM_PAD_ZERO      24'h00_0000
`define UCM_STAT_PAD      3'h0
`define UCM_LINE_IDLE     1'h1

// ----------------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------------
`define UCM_RESP_OKAY     2'h0
`define UCM_RESP_SLVERR   2'h2

`endif

//--- logic/ucm_loopback.sv
// Channel mode selection, echo and loopback routing with its register slave.
// Overview of operation
// - Setup register at direct and pointer locations
// - Bits 7:6 select the channel mode
// - Normal mode: no internal serial path
// - Echo mode retransmits received bits automatically
// - Echo output timed by receiver bit clock
// - Echo mode holds transmitter ready, idle inactive
// - Echo checks parity, resends parity as received
// - Echo checks framing, resends stops, queues characters
// - Break echoed until next valid start bit
// - Echo blocks processor writes to transmitter
// - Local loopback feeds transmitter into receiver
// - Local loopback receiver uses transmitter bit clock
// - Local loopback holds serial output high
// - Local loopback keeps processor paths normal
// - Remote loopback retransmits on receiver bit clock
// - Remote loopback hides characters and errors
// - Remote loopback skips parity, resends parity
// - Remote loopback skips framing, resends stops
`timescale 1ns/100ps
`default_nettype none
`include "ucm_defs.svh"

module ucm_loopback
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Surrounding channel control
   input  wire logic        rx_enable,
   input  wire logic        tx_enable,
   input  wire logic        pointer_rewind,
   output logic [5:0]       setup_other_bits,
   // Serial pins
   input  wire logic        rxd_pin,
   output logic             txd_pin,
   // Bit clock enables from the baud logic
   input  wire logic        rx_bit_en,
   input  wire logic        tx_bit_en,
   output logic             rx_timing_en,
   // Transmitter side
   input  wire logic        tx_serial,
   input  wire logic        tx_ready_raw,
   input  wire logic        tx_idle_raw,
   output logic             transmit_ready_flag,
   output logic             tx_idle_flag,
   // Processor to transmitter
   input  wire logic        host_tx_wr,
   input  wire logic [7:0]  host_tx_data,
   output logic             tx_write_en,
   output logic [7:0]       tx_write_data,
   // Receiver side
   output logic             rx_serial_in,
   output logic             parity_check_en,
   output logic             frame_check_en,
   input  wire logic        rx_start_seen,
   input  wire logic        rx_break_seen,
   input  wire logic        rx_char_valid,
   input  wire logic [7:0]  rx_char_data,
   input  wire logic        rx_parity_err,
   input  wire logic        rx_frame_err,
   input  wire logic        rx_break_err,
   // Receiver to receive queue
   output logic             rx_queue_wr,
   output logic [7:0]       rx_queue_data,
   output logic             parity_err_flag,
   output logic             frame_err_flag,
   output logic             break_err_flag
);

   // ----------------------------------------------------------------------------
   // Address decoding
   // ----------------------------------------------------------------------------
   function automatic logic [5:0] ucm_index(input logic [7:0] addr);
      ucm_index = addr[`UCM_ADDR_W-1:`UCM_IDX_LSB];
   endfunction

   function automatic logic ucm_mapped(input logic [7:0] addr);
      logic [5:0] idx;
      idx = ucm_index(addr);
      if (idx == `UCM_IDX_POINTER)
         ucm_mapped = 1'b1;
      else if (idx == `UCM_IDX_SETUP)
         ucm_mapped = 1'b1;
      else if (idx == `UCM_IDX_STATUS)
         ucm_mapped = 1'b1;
      else
         ucm_mapped = 1'b0;
   endfunction

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic                aw_held;
   logic [7:0]          aw_addr;
   logic                w_held;
   logic [7:0]          w_byte;
   logic                w_lane0;
   logic                wr_fire;
   logic [5:0]          wr_idx;
   logic                rd_fire;
   logic [5:0]          rd_idx;
   logic                setup_wr;
   logic [7:0]          setup_value;
   ucm_pkg::ucm_ptr_t   pointer;
   ucm_pkg::ucm_mode_t  mode;
   logic                is_echo;
   logic                is_local;
   logic                is_remote;
   logic                echo_path;
   logic                echo_bit;
   logic                break_active;
   logic                config_warn;
   logic [7:0]          status_value;
   logic [31:0]         next_rdata;

   // ----------------------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx        = ucm_index(aw_addr);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= `UCM_BYTE_ZERO;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held  <= 1'b0;
         w_byte  <= `UCM_BYTE_ZERO;
         w_lane0 <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held  <= 1'b1;
         w_byte  <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end
      else if (wr_fire)
         w_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `UCM_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= ucm_mapped(aw_addr) ? `UCM_RESP_OKAY : `UCM_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ----------------------------------------------------------------------------
   // Read channels
   // ----------------------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign rd_idx        = ucm_index(s_axi_araddr);

   always_comb
   begin
      next_rdata = `UCM_WORD_ZERO;
      if (rd_idx == `UCM_IDX_SETUP)
         next_rdata = {`UCM_PAD_ZERO, setup_value};
      else if (rd_idx == `UCM_IDX_POINTER && pointer == ucm_pkg::PTR_SETUP)
         next_rdata = {`UCM_PAD_ZERO, setup_value};
      else if (rd_idx == `UCM_IDX_STATUS)
         next_rdata = {`UCM_PAD_ZERO, status_value};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= `UCM_WORD_ZERO;
         s_axi_rresp  <= `UCM_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= ucm_mapped(s_axi_araddr) ? `UCM_RESP_OKAY : `UCM_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------------------
   // Channel setup register and legacy pointer
   // ----------------------------------------------------------------------------
   // The pointer location reaches the setup register once the first mode register has been passed.
   assign setup_wr = wr_fire && w_lane0 &&
                     ((wr_idx == `UCM_IDX_SETUP) ||
                      (wr_idx == `UCM_IDX_POINTER && pointer == ucm_pkg::PTR_SETUP));

   ucm_byte_reg u_setup
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (setup_wr),
      .wr_data (w_byte),
      .value   (setup_value)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pointer <= ucm_pkg::PTR_FIRST;
      else if ((wr_fire && wr_idx == `UCM_IDX_POINTER) || (rd_fire && rd_idx == `UCM_IDX_POINTER))
         pointer <= ucm_pkg::PTR_SETUP;
      else if (pointer_rewind)
         pointer <= ucm_pkg::PTR_FIRST;
   end

   assign mode             = ucm_pkg::ucm_mode_t'(setup_value[`UCM_MODE_MSB:`UCM_MODE_LSB]);
   assign is_echo          = (mode == ucm_pkg::MODE_ECHO);
   assign is_local         = (mode == ucm_pkg::MODE_LOCAL);
   assign is_remote        = (mode == ucm_pkg::MODE_REMOTE);
   assign echo_path        = is_echo || is_remote;
   assign setup_other_bits = setup_value[`UCM_MODE_LSB-1:0];

   // Flags a mode whose required side of the channel is switched off.
   assign config_warn  = (echo_path && !rx_enable) ||
                         (is_local && !tx_enable);
   assign status_value = {`UCM_STAT_PAD, config_warn, break_active, pointer, mode};

   // ----------------------------------------------------------------------------
   // Echo retiming
   // ----------------------------------------------------------------------------
   ucm_retimer u_retimer
   (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .active       (echo_path),
      .bit_en       (rx_bit_en),
      .din          (rxd_pin),
      .start_seen   (rx_start_seen),
      .break_seen   (rx_break_seen),
      .echo_bit     (echo_bit),
      .break_active (break_active)
   );

   // ----------------------------------------------------------------------------
   // Serial routing
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         txd_pin <= `UCM_LINE_IDLE;
      else
      begin
         case (mode)
            ucm_pkg::MODE_NORMAL : txd_pin <= tx_serial;
            ucm_pkg::MODE_LOCAL  : txd_pin <= `UCM_LINE_IDLE;
            // Parity and stop bits go out exactly as sampled; a break stays low until a start bit.
            default              : txd_pin <= break_active ? 1'b0 : echo_bit;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_serial_in <= `UCM_LINE_IDLE;
      else if (is_local)
         rx_serial_in <= tx_serial;
      else
         rx_serial_in <= rxd_pin;
   end

   assign rx_timing_en = is_local ? tx_bit_en : rx_bit_en;

   // ----------------------------------------------------------------------------
   // Transmitter gating
   // ----------------------------------------------------------------------------
   assign transmit_ready_flag = tx_ready_raw && !is_echo;
   assign tx_idle_flag        = tx_idle_raw && !is_echo;
   assign tx_write_en         = host_tx_wr && !is_echo;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_write_data <= `UCM_BYTE_ZERO;
      else if (host_tx_wr)
         tx_write_data <= host_tx_data;
   end

   // ----------------------------------------------------------------------------
   // Receiver gating
   // ----------------------------------------------------------------------------
   assign parity_check_en = !is_remote;
   assign frame_check_en  = !is_remote;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_queue_wr     <= 1'b0;
         rx_queue_data   <= `UCM_BYTE_ZERO;
         parity_err_flag <= 1'b0;
         frame_err_flag  <= 1'b0;
         break_err_flag  <= 1'b0;
      end
      else
      begin
         rx_queue_wr     <= rx_char_valid && !is_remote;
         rx_queue_data   <= rx_char_data;
         parity_err_flag <= rx_char_valid && rx_parity_err && !is_remote;
         frame_err_flag  <= rx_char_valid && rx_frame_err && !is_remote;
         break_err_flag  <= rx_break_err && !is_remote;
      end
   end

endmodule

`default_nettype wire

//--- logic/ucm_pkg.sv
// Types shared by the channel mode and loopback block.
package ucm_pkg;

   // Channel mode, in the order of its two-bit field encoding.
   typedef enum logic [1:0]
   {
      MODE_NORMAL,
      MODE_ECHO,
      MODE_LOCAL,
      MODE_REMOTE
   } ucm_mode_t;

   // Target of the legacy indirect pointer location.
   typedef enum logic
   {
      PTR_FIRST,
      PTR_SETUP
   } ucm_ptr_t;

endpackage

//--- logic/ucm_retimer.sv
// Re-clocks the received line on the receiver bit clock and tracks break echo.
`timescale 1ns/100ps
`default_nettype none
`include "ucm_defs.svh"

module ucm_retimer
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control and timing
   input  wire logic active,
   input  wire logic bit_en,
   // Received line and receiver events
   input  wire logic din,
   input  wire logic start_seen,
   input  wire logic break_seen,
   // Retimed line
   output logic      echo_bit,
   output logic      break_active
);

   // Each bit is resampled only on the receiver's own bit clock.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         echo_bit <= `UCM_LINE_IDLE;
      else if (!active)
         echo_bit <= `UCM_LINE_IDLE;
      else if (bit_en)
         echo_bit <= din;
   end

   // A break that arrives with a start bit keeps the break echo alive.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         break_active <= 1'b0;
      else if (!active)
         break_active <= 1'b0;
      else if (break_seen)
         break_active <= 1'b1;
      else if (start_seen)
         break_active <= 1'b0;
   end

endmodule

`default_nettype wire

//--- test/tb.sv
// Self-checking testbench for the channel mode and loopback block.
`timescale 1ns/100ps
`default_nettype none
`include "ucm_defs.svh"
module tb;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_enable;
   logic        tx_enable, pointer_rewind, rxd_pin, txd_pin, rx_bit_en, tx_bit_en, rx_timing_en, tx_serial;
   logic        tx_ready_raw, tx_idle_raw, transmit_ready_flag, tx_idle_flag, host_tx_wr, tx_write_en;
   logic        rx_serial_in, parity_check_en, frame_check_en, rx_start_seen, rx_break_seen, rx_char_valid;
   logic        rx_parity_err, rx_frame_err, rx_break_err, rx_queue_wr, parity_err_flag, frame_err_flag;
   logic        break_err_flag, send, busy;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, host_tx_data, tx_write_data, rx_char_data, rx_queue_data;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  s_axi_wstrb;
   logic [5:0]  setup_other_bits;
   logic [9:0]  frame, heard;
   int          miscompares, check_count, cyc;
   ucm_loopback i_dut (.*);
   ucm_line_model i_line (.aclk, .aresetn, .send, .frame, .busy, .heard, .txd_pin, .rxd_pin, .rx_bit_en);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
         r = s_axi_bresp;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   task axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
         {d, r} = {s_axi_rdata, s_axi_rresp};
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask
   task setmode(input logic [1:0] m);
      axw(8'h88, {24'h00_0000, m, 6'h00}, 4'hf);
      chk(r, `UCM_RESP_OKAY);
   endtask
   task t_regs;
      axr(8'h88);
      chk(d, 32'h0000_0000);
      for (int m = 0; m < 4; m++)
      begin
         axw(8'h88, {24'h00_0000, 2'(m), 6'h2a}, 4'hf);
         axr(8'h88);
         chk(d, {24'h00_0000, 2'(m), 6'h2a});
         chk(setup_other_bits, 6'h2a);
         axr(8'h90);
         chk(d, {27'h0, m != 0, 2'h0, 2'(m)});
      end
      axw(8'h88, 32'h0000_0000, 4'h0);
      axr(8'h88);
      chk(d, 32'h0000_00ea);
      axw(8'hfc, 32'h0000_0000, 4'hf);
      chk(r, `UCM_RESP_SLVERR);
      axr(8'hfc);
      chk({r, d}, {`UCM_RESP_SLVERR, 32'h0000_0000});
      setmode(ucm_pkg::MODE_NORMAL);
   endtask
   task t_ptr;
      axr(8'h00);
      chk(d, 32'h0000_0000);
      axw(8'h00, 32'h0000_0015, 4'hf);
      axr(8'h88);
      chk(d, 32'h0000_0015);
      @(posedge aclk);
      pointer_rewind <= 1'h1;
      @(posedge aclk);
      pointer_rewind <= 1'h0;
      axw(8'h00, 32'h0000_003f, 4'hf);
      axr(8'h00);
      chk(d, 32'h0000_0015);
   endtask
   task snd(input logic [9:0] f);
      @(posedge aclk);
      {frame, send} <= {f, 1'h1};
      while (!busy)
         @(posedge aclk);
      send <= 1'h0;
      while (busy)
         @(posedge aclk);
      chk(heard, f);
   endtask
   task rxc(input logic e);
      @(posedge aclk);
      {rx_char_valid, rx_char_data, rx_parity_err, rx_frame_err, rx_break_err} <= {1'h1, 8'h5c, 3'h7};
      @(posedge aclk);
      {rx_char_valid, rx_parity_err, rx_frame_err, rx_break_err} <= 4'h0;
      @(negedge aclk);
      chk({rx_queue_wr, parity_err_flag, frame_err_flag, break_err_flag}, {4{e}});
      if (e)
         chk(rx_queue_data, 8'h5c);
   endtask
   task txs(input logic e);
      @(posedge aclk);
      {tx_ready_raw, tx_idle_raw, host_tx_wr, host_tx_data} <= {3'h7, 7'h53, e};
      @(negedge aclk);
      chk({transmit_ready_flag, tx_idle_flag, tx_write_en}, {3{e}});
      @(posedge aclk);
      {tx_ready_raw, tx_idle_raw, host_tx_wr} <= 3'h0;
      @(negedge aclk);
      chk(tx_write_data, {7'h53, e});
   endtask
   task tbrk;
      @(posedge aclk);
      rx_break_seen <= 1'h1;
      @(posedge aclk);
      rx_break_seen <= 1'h0;
      repeat (12) @(posedge aclk);
      @(negedge aclk);
      chk(txd_pin, 1'h0);
      @(posedge aclk) rx_start_seen <= 1'h1;
      @(posedge aclk);
      rx_start_seen <= 1'h0;
      repeat (12) @(posedge aclk);
      @(negedge aclk);
      chk(txd_pin, 1'h1);
   endtask
   task lp(input logic l);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge aclk);
         {tx_serial, tx_bit_en} <= {1'(8'h96 >> i), ~1'(8'h96 >> i)};
         @(posedge aclk);
         @(negedge aclk);
         chk(rx_serial_in, l ? tx_serial : rxd_pin);
         chk(txd_pin, l ? 1'h1 : tx_serial);
         chk(rx_timing_en, l ? tx_bit_en : rx_bit_en);
      end
   endtask
   initial
   begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         give_verdict;
      end
   end
   initial
   begin
      {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, rx_enable, tx_enable, pointer_rewind, tx_bit_en} = '0;
      {tx_serial, tx_ready_raw, tx_idle_raw, host_tx_wr, host_tx_data, rx_start_seen, rx_break_seen} = '0;
      {rx_char_valid, rx_char_data, rx_parity_err, rx_frame_err, rx_break_err, send, frame} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs;
      t_ptr;
      lp(1'h0);
      txs(1'h1);
      rxc(1'h1);
      @(posedge aclk) rx_enable <= 1'h1;
      setmode(ucm_pkg::MODE_ECHO);
      txs(1'h0);
      rxc(1'h1);
      snd(10'h2b4);
      tbrk;
      setmode(ucm_pkg::MODE_REMOTE);
      rxc(1'h0);
      chk({parity_check_en, frame_check_en}, 2'h0);
      snd(10'h3ca);
      tbrk;
      @(posedge aclk) {rx_enable, tx_enable} <= 2'h1;
      setmode(ucm_pkg::MODE_LOCAL);
      lp(1'h1);
      txs(1'h1);
      rxc(1'h1);
      give_verdict;
   end
endmodule
`default_nettype wire

//--- test/ucm_line_model.sv
// Remote serial device: sends frames on the line and records what comes back.
`timescale 1ns/100ps
`default_nettype none
module ucm_line_model
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Frame request and result
   input  wire logic       send,
   input  wire logic [9:0] frame,
   output logic            busy,
   output logic      [9:0] heard,
   // Line side
   input  wire logic       txd_pin,
   output logic            rxd_pin,
   output logic            rx_bit_en
);
   logic [2:0] cnt;
   logic [3:0] idx;
   assign rx_bit_en = cnt == 3'h4;
   assign busy      = idx != 4'h0;
   // Each bit lasts eight cycles; the line idles high between frames.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt     <= 3'h0;
         idx     <= 4'h0;
         rxd_pin <= 1'h1;
         heard   <= 10'h000;
      end
      else
      begin
         cnt <= cnt + 3'h1;
         if (cnt == 3'h7 && busy)
            heard <= {txd_pin, heard[9:1]};
         if (cnt == 3'h7 && (busy || send))
         begin
            rxd_pin <= (idx == 4'ha) ? 1'h1 : frame[idx];
            idx     <= (idx == 4'ha) ? 4'h0 : idx + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/ucm_loopback_asserts.sv
// Concurrent checks on the ports of the channel mode and loopback block.
`timescale 1ns/100ps
`default_nettype none
module ucm_loopback_chk
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register writes
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   // Serial paths
   input wire logic        rxd_pin,
   input wire logic        txd_pin,
   input wire logic        tx_serial,
   input wire logic        rx_serial_in,
   input wire logic        rx_bit_en,
   input wire logic        tx_bit_en,
   input wire logic        rx_timing_en,
   // Transmitter side
   input wire logic        transmit_ready_flag,
   input wire logic        tx_idle_flag,
   input wire logic        host_tx_wr,
   input wire logic        tx_write_en,
   // Receiver side
   input wire logic        parity_check_en,
   input wire logic        frame_check_en,
   input wire logic        rx_char_valid,
   input wire logic [7:0]  rx_char_data,
   input wire logic        rx_queue_wr,
   input wire logic [7:0]  rx_queue_data,
   input wire logic        parity_err_flag,
   input wire logic        frame_err_flag,
   input wire logic        break_err_flag
);
   logic [7:0] aa;
   logic [1:0] wd;
   logic [1:0] md;
   logic       ws;
   logic       bq;
   logic       bq2;
   logic       quiet;
   logic       echo;
   logic       loc;
   logic       rem;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Mirrors the mode from direct writes; checks pause around each write response.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aa  <= 8'h00;
         wd  <= 2'h0;
         ws  <= 1'h0;
         md  <= 2'h0;
         bq  <= 1'h1;
         bq2 <= 1'h1;
      end
      else
      begin
         bq  <= s_axi_bvalid;
         bq2 <= bq;
         if (s_axi_awvalid && s_axi_awready)
            aa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wd <= s_axi_wdata[7:6];
            ws <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid && !bq && aa == 8'h88 && ws)
            md <= wd;
      end
   end
   assign quiet = !s_axi_bvalid && !bq && !bq2;
   assign echo  = md == ucm_pkg::MODE_ECHO;
   assign loc   = md == ucm_pkg::MODE_LOCAL;
   assign rem   = md == ucm_pkg::MODE_REMOTE;
   a_local_txd_high: assert property (quiet && loc |-> txd_pin)
      else $error("txd not high in local loopback");
   a_local_rx_feed: assert property (quiet && loc |-> ##1 rx_serial_in == $past(tx_serial))
      else $error("receiver not fed from transmitter");
   a_pin_rx_feed: assert property (quiet && !loc |-> ##1 rx_serial_in == $past(rxd_pin))
      else $error("receiver not fed from pin");
   a_normal_txd_path: assert property (quiet && md == ucm_pkg::MODE_NORMAL |-> ##1 txd_pin == $past(tx_serial))
      else $error("txd not from transmitter in normal mode");
   a_bit_clock_sel: assert property (quiet |-> rx_timing_en == (loc ? tx_bit_en : rx_bit_en))
      else $error("wrong bit clock selected");
   a_echo_status_off: assert property (quiet && echo |-> !transmit_ready_flag && !tx_idle_flag)
      else $error("transmitter status active in echo");
   a_tx_link_gate: assert property (quiet |-> tx_write_en == (host_tx_wr && !echo))
      else $error("transmitter write gating wrong");
   a_check_gate: assert property (quiet |-> parity_check_en == !rem && frame_check_en == !rem)
      else $error("parity or framing check gating wrong");
   a_remote_hidden: assert property (quiet && rem |-> !rx_queue_wr && !parity_err_flag && !frame_err_flag && !break_err_flag)
      else $error("receive data or errors visible in remote loopback");
   a_queue_pass: assert property (quiet && !rem && rx_char_valid |=> rx_queue_wr && rx_queue_data == $past(rx_char_data))
      else $error("received character not queued");
endmodule
bind ucm_loopback ucm_loopback_chk i_chk
(
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .rxd_pin, .txd_pin, .tx_serial, .rx_serial_in,
   .rx_bit_en, .tx_bit_en, .rx_timing_en, .transmit_ready_flag, .tx_idle_flag, .host_tx_wr,
   .tx_write_en, .parity_check_en, .frame_check_en, .rx_char_valid, .rx_char_data, .rx_queue_wr,
   .rx_queue_data, .parity_err_flag, .frame_err_flag, .break_err_flag
);
`default_nettype wire
